// ### design/ccd_byte_cmp.sv
/*
  moves source bytes to the destination, or in compare mode checks them byte by byte.
  assumes clear_in is pulsed before each command's data phase.
*/
`timescale 1ns/1ps
module ccd_byte_cmp (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clear_in,
  input  wire logic       en_in,
  input  wire logic       cmp_mode_in,
  input  wire logic [7:0] src_in,
  input  wire logic [7:0] dst_in,
  output logic            wr_out,
  output logic [7:0]      wr_byte_out,
  output logic            miscmp_out
);

  logic       wr_q;
  logic [7:0] wr_byte_q;
  logic       miscmp_q;

  wire logic differ = en_in && cmp_mode_in && (src_in != dst_in);

  // compare never writes, so the destination stays untouched on a mismatch
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_q      <= 1'b0;
      wr_byte_q <= 8'h00;
      miscmp_q  <= 1'b0;
    end else begin
      wr_q <= en_in && !cmp_mode_in;
      if (en_in) begin
        wr_byte_q <= src_in;
      end
      miscmp_q <= differ || (miscmp_q && !clear_in);   // sticky; a new mismatch beats clear
    end
  end

  assign wr_out      = wr_q;
  assign wr_byte_out = wr_byte_q;
  assign miscmp_out  = miscmp_q;

endmodule : ccd_byte_cmp

// ### design/ccd_cdb_parse.sv
/*
  collects the bytes of a command block and pulls out the copy/compare fields.
  assumes start_in marks byte zero and bytes arrive one per valid cycle.
*/
`timescale 1ns/1ps
module ccd_cdb_parse
  import ccd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        valid_in,
  input  wire logic        start_in,
  output logic             done_out,
  output logic             compare_out,
  output logic             bad_op_out,
  output logic [2:0]       lun_out,
  output logic             pad_out,
  output logic [23:0]      len_out
);

  logic [3:0] idx_q;
  logic       active_q;
  logic       done_q;
  logic       bad_q;
  logic       cmp_q;
  logic [2:0] lun_q;
  logic       pad_q;
  logic [23:0] len_q;

  // ==========================================================================
  // per-opcode layout selection
  wire logic       is_copy  = (byte_in == OP_COPY);
  wire logic       is_cmp   = (byte_in == OP_COMPARE);
  wire logic [3:0] len_lo   = cmp_q ? CMP_LEN_LO : CPY_LEN_LO;
  wire logic [3:0] last_idx = cmp_q ? CMP_LAST : CPY_LAST;
  wire logic       take     = valid_in && !start_in && active_q;
  wire logic       in_len   = (idx_q >= len_lo) && (idx_q <= len_lo + LEN_SPAN);

  // byte walk; other opcodes finish at once flagged as not ours
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_q    <= 4'h0;
      active_q <= 1'b0;
      done_q   <= 1'b0;
      bad_q    <= 1'b0;
      cmp_q    <= 1'b0;
      lun_q    <= 3'h0;
      pad_q    <= 1'b0;
      len_q    <= 24'h000000;
    end else begin
      done_q <= 1'b0;
      if (valid_in && start_in) begin
        idx_q    <= 4'h1;
        cmp_q    <= is_cmp;
        active_q <= is_copy || is_cmp;
        done_q   <= !(is_copy || is_cmp);
        bad_q    <= !(is_copy || is_cmp);
        len_q    <= 24'h000000;
      end else if (take) begin
        idx_q <= idx_q + 4'h1;
        if (idx_q == LUN_BYTE) begin
          lun_q <= byte_in[LUN_MSB:LUN_LSB];
          pad_q <= byte_in[PAD_BIT];
        end
        if (in_len) begin
          len_q <= {len_q[15:0], byte_in};   // msb first
        end
        if (idx_q == last_idx) begin
          active_q <= 1'b0;
          done_q   <= 1'b1;
        end
      end
    end
  end

  assign done_out    = done_q;
  assign compare_out = cmp_q;
  assign bad_op_out  = bad_q;
  assign lun_out     = lun_q;
  assign pad_out     = pad_q;
  assign len_out     = len_q;

endmodule : ccd_cdb_parse

// ### design/ccd_pkg.sv
/*
  shared constants, types and decode helpers of the copy/compare command decoder.
  assumes one clock domain; every user imports the whole package.
*/
package ccd_pkg;

  // ==========================================================================
  // command block layout
  localparam logic [7:0] OP_COPY      = 8'h18;
  localparam logic [7:0] OP_COMPARE   = 8'h39;
  localparam logic [3:0] CPY_LAST     = 4'h5;   // control byte of the six-byte block
  localparam logic [3:0] CMP_LAST     = 4'h9;   // control byte of the ten-byte block
  localparam logic [3:0] CPY_LEN_LO   = 4'h2;   // first length byte, msb first
  localparam logic [3:0] CMP_LEN_LO   = 4'h3;
  localparam logic [3:0] LEN_SPAN     = 4'h2;   // three length bytes: lo .. lo+2
  localparam logic [3:0] LUN_BYTE     = 4'h1;
  localparam int         LUN_MSB      = 7;
  localparam int         LUN_LSB      = 5;
  localparam int         PAD_BIT      = 0;

  // ==========================================================================
  // parameter list header and descriptors
  localparam logic [23:0] HDR_LEN     = 24'h000004;
  localparam logic [23:0] HDR_FUNC    = 24'h000000;
  localparam int          FUNC_MSB    = 7;
  localparam int          FUNC_LSB    = 3;
  localparam int          PRIO_MSB    = 2;
  localparam int          PRIO_LSB    = 0;
  localparam int          CAT_BIT     = 3;
  localparam logic [9:0]  MAX_SEG     = 10'h100;
  localparam logic [2:0]  OTHER_PRIO  = 3'h1;   // priority of every other command

  localparam logic [4:0] FN_BLK_STR = 5'h00;
  localparam logic [4:0] FN_STR_BLK = 5'h01;
  localparam logic [4:0] FN_BLK_BLK = 5'h02;
  localparam logic [4:0] FN_STR_STR = 5'h03;
  localparam logic [4:0] FN_IMAGE   = 5'h04;
  localparam logic [4:0] DT_SEQ     = 5'h01;    // sequential-access device type

  typedef enum logic [2:0] {FMT_BLK_STR, FMT_BLK_BLK, FMT_STR_STR, FMT_IMAGE, FMT_NONE} ccd_fmt_type;
  typedef enum logic [2:0] {ST_IDLE, ST_CDB, ST_PARAM, ST_EXEC, ST_DONE} ccd_state_type;

  // ==========================================================================
  // device type classes
  function automatic logic ccd_is_block(input logic [4:0] t);
    ccd_is_block = (t == 5'h00) || (t == 5'h04) || (t == 5'h05) || (t == 5'h07);
  endfunction : ccd_is_block

  function automatic logic ccd_is_stream(input logic [4:0] t);
    ccd_is_stream = (t == 5'h01) || (t == 5'h02) || (t == 5'h03) || (t == 5'h09);
  endfunction : ccd_is_stream

endpackage : ccd_pkg

// ### design/ccd_top.sv
/*
  copy manager front end: decodes COPY and COMPARE blocks, walks the parameter list,
  runs the byte move or compare and reports status with sense fields.
  assumes the bus phase logic feeds command and DATA OUT bytes and a data engine
  supplies source/destination bytes while copy_run_out is high.
*/
// What this block does
// - copy block: six bytes, opcode, length, control
// - compare block: ten bytes, length in three-five
// - compare checks bytes instead of writing destination
// - mismatch ends compare with miscompare check
// - zero list length is fine, no data
// - four-byte header: function, priority, then descriptors
// - function code picks descriptor layout; subset allowed
// - codes zero to four name the transfers
// - block and stream device types grouped
// - copy scheduled by priority, others one
// - at most 256 descriptors, numbered upward
// - pad and catenate steer partial blocks
// - this unit manages the copy; third-party optional
// - unsupported arrangement gives illegal request
`timescale 1ns/1ps
module ccd_top
  import ccd_pkg::*;
#(
  parameter logic [4:0] FUNC_MASK   = 5'h1f,  // supported function codes, bit per code
  parameter bit         THIRD_PARTY = 1'b0,   // manage copies between two other units
  parameter int         SEG_LEN_BS  = 12,     // block/stream descriptor bytes
  parameter int         SEG_LEN_BB  = 16,
  parameter int         SEG_LEN_SS  = 16,
  parameter int         SEG_LEN_IMG = 16,
  parameter logic [3:0] SK_ILLEGAL  = 4'h5,
  parameter logic [3:0] SK_MISCMP   = 4'he,
  parameter logic [7:0] ASC_BAD_PAR = 8'h26
) (
  input  wire logic                 mclk_in,
  input  wire logic                 rst_b_in,
  input  wire logic [7:0]           cdb_byte_in,
  input  wire logic                 cdb_valid_in,
  input  wire logic                 cdb_start_in,
  input  wire logic [7:0]           par_byte_in,
  input  wire logic                 par_valid_in,
  input  wire logic [4:0]           own_type_in,
  input  wire logic                 other_pending_in,
  input  wire logic [7:0]           src_byte_in,
  input  wire logic [7:0]           dst_byte_in,
  input  wire logic                 xfer_valid_in,
  input  wire logic                 xfer_done_in,
  output logic                      busy_out,
  output logic                      want_data_out,
  output logic [23:0]               par_len_out,
  output logic                      compare_out,
  output logic [2:0]                lun_out,
  output logic                      pad_out,
  output logic                      cat_out,
  output logic [4:0]                func_out,
  output ccd_pkg::ccd_fmt_type      seg_fmt_out,
  output logic [7:0]                desc_byte_out,
  output logic                      desc_valid_out,
  output logic [4:0]                desc_pos_out,
  output logic [9:0]                desc_idx_out,
  output logic [2:0]                sched_prio_out,
  output logic                      copy_run_out,
  output logic                      other_hold_out,
  output logic [7:0]                dst_byte_out,
  output logic                      dst_wr_out,
  output logic                      done_out,
  output logic                      check_out,
  output logic [3:0]                sense_key_out,
  output logic [7:0]                asc_out,
  output logic [9:0]                seg_num_out
);

  // elaboration check: position counters are five bits wide
  if (SEG_LEN_BS < 1 || SEG_LEN_BS > 31 || SEG_LEN_BB < 1 || SEG_LEN_BB > 31 ||
      SEG_LEN_SS < 1 || SEG_LEN_SS > 31 || SEG_LEN_IMG < 1 || SEG_LEN_IMG > 31) begin : g_bad_seg_len
    $error("descriptor lengths must lie in 1..31");
  end

  // ==========================================================================
  // command block parser
  logic        cdb_done;
  logic        cdb_cmp;
  logic        cdb_bad;
  logic [2:0]  cdb_lun;
  logic        cdb_pad;
  logic [23:0] cdb_len;

  ccd_cdb_parse u_parse (
    .clk_in      (mclk_in),
    .rst_b_in    (rst_b_in),
    .byte_in     (cdb_byte_in),
    .valid_in    (cdb_valid_in),
    .start_in    (cdb_start_in),
    .done_out    (cdb_done),
    .compare_out (cdb_cmp),
    .bad_op_out  (cdb_bad),
    .lun_out     (cdb_lun),
    .pad_out     (cdb_pad),
    .len_out     (cdb_len)
  );

  // ==========================================================================
  // state and held fields
  ccd_state_type st_q, st_d;
  logic        cmp_q;
  logic        pad_q;
  logic        cat_q;
  logic [2:0]  lun_q;
  logic [23:0] len_q;
  logic [23:0] pcnt_q;
  logic [4:0]  func_q;
  logic [2:0]  prio_q;
  logic        func_bad_q;
  logic [4:0]  segpos_q;
  logic [9:0]  segidx_q;
  logic        err_q;
  ccd_fmt_type fmt_q;
  logic [7:0]  dbyte_q;
  logic        dvalid_q;
  logic [4:0]  dpos_q;
  logic [9:0]  didx_q;
  logic        busy_q;
  logic        want_q;
  logic [2:0]  sprio_q;
  logic        run_q;
  logic        hold_q;
  logic        done_q;
  logic        check_q;
  logic [3:0]  sk_q;
  logic [7:0]  asc_q;
  logic [9:0]  segnum_q;

  // ==========================================================================
  // header decode: layout and support of the arrangement
  wire logic [4:0] hdr_func = par_byte_in[FUNC_MSB:FUNC_LSB];
  wire logic [2:0] hdr_prio = par_byte_in[PRIO_MSB:PRIO_LSB];
  // codes map onto the shared block and stream layouts
  wire ccd_fmt_type hdr_fmt = (hdr_func == FN_BLK_STR || hdr_func == FN_STR_BLK) ? FMT_BLK_STR :
                              (hdr_func == FN_BLK_BLK) ? FMT_BLK_BLK :
                              (hdr_func == FN_STR_STR) ? FMT_STR_STR :
                              (hdr_func == FN_IMAGE)   ? FMT_IMAGE : FMT_NONE;
  wire logic own_blk = ccd_is_block(own_type_in);
  wire logic own_str = ccd_is_stream(own_type_in);
  // without third-party support this unit must be the source or the destination
  wire logic own_in  = (hdr_fmt == FMT_BLK_STR) ? (own_blk || own_str) :
                       (hdr_fmt == FMT_BLK_BLK) ? own_blk :
                       (hdr_fmt == FMT_STR_STR) ? own_str :
                       (own_type_in == DT_SEQ);
  // mask widened to eight so codes five to seven never index past its end
  wire logic [7:0] func_mask8 = {3'h0, FUNC_MASK};
  // unlisted code, masked subset, or foreign arrangement is refused
  wire logic hdr_bad = (hdr_fmt == FMT_NONE) || !func_mask8[hdr_func[2:0]] || (hdr_func > FN_IMAGE) ||
                       (!THIRD_PARTY && !own_in);
  wire logic [4:0] seg_len = (fmt_q == FMT_BLK_STR) ? 5'(SEG_LEN_BS) :
                             (fmt_q == FMT_BLK_BLK) ? 5'(SEG_LEN_BB) :
                             (fmt_q == FMT_STR_STR) ? 5'(SEG_LEN_SS) : 5'(SEG_LEN_IMG);

  // ==========================================================================
  // parameter list walk
  wire logic        par_take  = (st_q == ST_PARAM) && par_valid_in;
  wire logic        in_hdr    = pcnt_q < HDR_LEN;
  wire logic        par_last  = par_take && (pcnt_q == len_q - 24'h000001);
  wire logic        seg_wrap  = par_take && !in_hdr && (segpos_q == seg_len - 5'h01);
  wire logic [4:0]  segpos_d  = seg_wrap ? 5'h00 : (segpos_q + 5'h01);
  wire logic [9:0]  segidx_d  = (seg_wrap && segidx_q != 10'h3ff) ? segidx_q + 10'h001 : segidx_q;
  wire logic        hdr0_now  = par_take && (pcnt_q == HDR_FUNC);
  wire logic        func_bad  = hdr0_now ? hdr_bad : func_bad_q;
  // short header, header with no descriptors, ragged tail, too many descriptors or refused function
  wire logic        list_err  = (len_q < HDR_LEN) || (in_hdr ? 1'b0 : (segpos_d != 5'h00)) ||
                                (segidx_d > MAX_SEG) || func_bad || (len_q == HDR_LEN);
  wire logic        eng_en    = (st_q == ST_EXEC) && xfer_valid_in && run_q;

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (cdb_valid_in && cdb_start_in) st_d = ST_CDB;
      ST_CDB:   if (cdb_done) st_d = cdb_bad ? ST_IDLE : ((cdb_len == 24'h000000) ? ST_DONE : ST_PARAM);
      ST_PARAM: if (par_last) st_d = list_err ? ST_DONE : ST_EXEC;
      ST_EXEC:  if (xfer_done_in) st_d = ST_DONE;
      ST_DONE:  st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  // command capture and list bookkeeping
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= ST_IDLE; cmp_q <= 1'b0; pad_q <= 1'b0; lun_q <= 3'h0; len_q <= 24'h000000;
      pcnt_q <= 24'h000000; func_q <= 5'h00; prio_q <= OTHER_PRIO; func_bad_q <= 1'b0;
      segpos_q <= 5'h00; segidx_q <= 10'h000; err_q <= 1'b0; fmt_q <= FMT_NONE; cat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == ST_CDB && cdb_done) begin
        cmp_q <= cdb_cmp; pad_q <= cdb_pad; lun_q <= cdb_lun; len_q <= cdb_len;
        pcnt_q <= 24'h000000; segpos_q <= 5'h00; segidx_q <= 10'h000; err_q <= 1'b0;
        func_bad_q <= 1'b0;
      end
      if (par_take) begin
        pcnt_q <= pcnt_q + 24'h000001;
        if (!in_hdr) segpos_q <= segpos_d;
        segidx_q <= segidx_d;
        if (!in_hdr && segpos_q == 5'h00) cat_q <= par_byte_in[CAT_BIT];   // per-descriptor catenate
      end
      if (hdr0_now) begin
        func_q <= hdr_func; prio_q <= hdr_prio; fmt_q <= hdr_fmt; func_bad_q <= hdr_bad;
      end
      if (par_last) err_q <= list_err;
    end
  end

  // ==========================================================================
  // byte engine
  logic miscmp;
  ccd_byte_cmp u_cmp (
    .clk_in      (mclk_in),
    .rst_b_in    (rst_b_in),
    .clear_in    (st_q == ST_CDB),
    .en_in       (eng_en),
    .cmp_mode_in (cmp_q),
    .src_in      (src_byte_in),
    .dst_in      (dst_byte_in),
    .wr_out      (dst_wr_out),
    .wr_byte_out (dst_byte_out),
    .miscmp_out  (miscmp)
  );

  // descriptor bytes forwarded with their position and number
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dbyte_q <= 8'h00; dvalid_q <= 1'b0; dpos_q <= 5'h00; didx_q <= 10'h000;
    end else begin
      dvalid_q <= par_take && !in_hdr;
      dbyte_q  <= par_byte_in;
      dpos_q   <= segpos_q;
      didx_q   <= segidx_q;   // ascending from zero in arrival order
    end
  end

  // scheduling: an urgent copy holds others back, a lax one yields to them
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sprio_q <= OTHER_PRIO; run_q <= 1'b0; hold_q <= 1'b0; busy_q <= 1'b0; want_q <= 1'b0;
    end else begin
      sprio_q <= (st_d == ST_EXEC) ? prio_q : OTHER_PRIO;
      run_q   <= (st_d == ST_EXEC) && !(other_pending_in && prio_q > OTHER_PRIO);
      hold_q  <= (st_d == ST_EXEC) && (prio_q < OTHER_PRIO);
      busy_q  <= st_d != ST_IDLE;
      want_q  <= (st_d == ST_PARAM) && !par_last;
    end
  end

  // status: list errors are illegal requests, compare mismatches miscompare
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_q <= 1'b0; check_q <= 1'b0; sk_q <= 4'h0; asc_q <= 8'h00; segnum_q <= 10'h000;
    end else begin
      done_q <= st_q == ST_DONE;
      if (st_q == ST_DONE) begin
        check_q  <= err_q || (cmp_q && miscmp);
        sk_q     <= err_q ? SK_ILLEGAL : ((cmp_q && miscmp) ? SK_MISCMP : 4'h0);
        asc_q    <= err_q ? ASC_BAD_PAR : 8'h00;
        segnum_q <= segidx_q;                                      // same fields as a failed copy
      end
    end
  end

  assign busy_out = busy_q;         assign want_data_out = want_q;   assign par_len_out = len_q;
  assign compare_out = cmp_q;       assign lun_out = lun_q;          assign pad_out = pad_q;
  assign cat_out = cat_q;           assign func_out = func_q;        assign seg_fmt_out = fmt_q;
  assign desc_byte_out = dbyte_q;   assign desc_valid_out = dvalid_q; assign desc_pos_out = dpos_q;
  assign desc_idx_out = didx_q;     assign sched_prio_out = sprio_q; assign copy_run_out = run_q;
  assign other_hold_out = hold_q;   assign done_out = done_q;        assign check_out = check_q;
  assign sense_key_out = sk_q;      assign asc_out = asc_q;          assign seg_num_out = segnum_q;

  // ==========================================================================
  // assertions
  property p_zero_len;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (st_q == ST_CDB && cdb_done && !cdb_bad && cdb_len == 24'h000000) |-> ##2 (done_q && !check_q);
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero length list not clean");
  property p_miscmp;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (st_q == ST_EXEC && xfer_done_in && cmp_q && miscmp) |-> ##2 (done_q && check_q && sk_q == SK_MISCMP);
  endproperty
  a_miscmp: assert property (p_miscmp) else $error("miscompare not reported");
  property p_no_write;
    @(posedge mclk_in) disable iff (!rst_b_in) (st_q == ST_EXEC && cmp_q) |=> !dst_wr_out;
  endproperty
  a_no_write: assert property (p_no_write) else $error("compare wrote destination");
  property p_copy_write;
    @(posedge mclk_in) disable iff (!rst_b_in) (eng_en && !cmp_q) |=> (dst_wr_out && dst_byte_out == $past(src_byte_in));
  endproperty
  a_copy_write: assert property (p_copy_write) else $error("copy byte not written");
  property p_yield;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (st_q == ST_EXEC && st_d == ST_EXEC && other_pending_in && prio_q > OTHER_PRIO) |=> !copy_run_out;
  endproperty
  a_yield: assert property (p_yield) else $error("lax copy did not yield");
  property p_idle_prio;
    @(posedge mclk_in) disable iff (!rst_b_in) (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> sched_prio_out == OTHER_PRIO;
  endproperty
  a_idle_prio: assert property (p_idle_prio) else $error("idle priority not one");
  property p_ragged;
    @(posedge mclk_in) disable iff (!rst_b_in)
      (par_last && !in_hdr && segpos_d != 5'h00) |-> ##2 (done_q && check_q && sk_q == SK_ILLEGAL && asc_q == ASC_BAD_PAR);
  endproperty
  a_ragged: assert property (p_ragged) else $error("ragged list accepted");
  property p_bad_func;
    @(posedge mclk_in) disable iff (!rst_b_in) (par_last && func_bad) |-> ##2 (check_q && sk_q == SK_ILLEGAL);
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("unsupported function accepted");
  property p_seg_count;
    @(posedge mclk_in) disable iff (!rst_b_in) (seg_wrap && segidx_q < MAX_SEG) |=> segidx_q == $past(segidx_q) + 10'h001;
  endproperty
  a_seg_count: assert property (p_seg_count) else $error("descriptor number not ascending");

endmodule : ccd_top

// ### test/ccd_host_model.sv
/*
  initiator model: sends command blocks and the DATA OUT parameter list.
  assumes one calling process, driving on the rising edge of mclk_in.
*/
`timescale 1ns/1ps
module ccd_host_model
  import ccd_pkg::*;
(
  input  wire logic  mclk_in,
  input  wire logic  want_in,
  output logic [7:0] cdb_byte_out,
  output logic       cdb_valid_out,
  output logic       cdb_start_out,
  output logic [7:0] par_byte_out,
  output logic       par_valid_out
);
  // ==========================================================
  // byte drivers; a released line flips so no stale byte shows
  initial begin
    {cdb_valid_out, cdb_start_out, par_valid_out} = 3'h0;
    {cdb_byte_out, par_byte_out} = 16'h5aa5;
  end
  task automatic put(input bit par, input logic [7:0] b, input bit first);
    @(posedge mclk_in);
    if (par) {par_byte_out, par_valid_out} <= {b, 1'b1};
    else {cdb_byte_out, cdb_valid_out, cdb_start_out} <= {b, 1'b1, first};
  endtask : put
  task automatic rel();
    @(posedge mclk_in);
    {cdb_valid_out, cdb_start_out, par_valid_out} <= 3'h0;
    {cdb_byte_out, par_byte_out} <= ~{cdb_byte_out, par_byte_out};
  endtask : rel
  // length goes msb first; lun 2 with pad set
  task automatic send_cmd(input bit cmp, input logic [23:0] n);
    logic [7:0] q[$];
    if (cmp) q = '{OP_COMPARE, 8'h41, 8'h00, n[23:16], n[15:8], n[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    else q = '{OP_COPY, 8'h41, n[23:16], n[15:8], n[7:0], 8'h00};
    foreach (q[i]) put(1'b0, q[i], i == 0);
    rel();
  endtask : send_cmd
  // list bytes once the block asks for them, or after 50 cycles without asking
  task automatic send_list(input logic [7:0] l[$]);
    for (int i = 0; i < 50 && want_in !== 1'b1; i++) @(posedge mclk_in);
    foreach (l[i]) put(1'b1, l[i], 1'b0);
    rel();
  endtask : send_list
endmodule : ccd_host_model

// ### test/test_copy_compare_command_decoder.sv
/*
  self-checking bench of the copy/compare decoder with a queue model of the data path.
  assumes ccd_host_model plays the initiator; third-party copies are off, own device type varies.
*/
`timescale 1ns/1ps
module test_copy_compare_command_decoder;
  import ccd_pkg::*;
  logic       mclk_in, rst_b_in, cdb_valid_in, cdb_start_in, par_valid_in, other_pending_in;
  logic       xfer_valid_in, xfer_done_in, want_data_out, copy_run_out, dst_wr_out, done_out, check_out;
  logic       compare_out, pad_out, cat_out, other_hold_out;
  logic [2:0] lun_out;
  logic [4:0] func_out;
  logic [23:0] par_len_out;
  logic [9:0] seg_num_out;
  logic [7:0] cdb_byte_in, par_byte_in, src_byte_in, dst_byte_in, dst_byte_out, asc_out;
  logic [4:0] own_type_in;
  logic [3:0] sense_key_out;
  logic [2:0] sched_prio_out;
  logic [7:0] exp_q[$];
  int         error_cnt, checks;
  ccd_host_model host (.mclk_in(mclk_in), .want_in(want_data_out), .cdb_byte_out(cdb_byte_in),
    .cdb_valid_out(cdb_valid_in), .cdb_start_out(cdb_start_in), .par_byte_out(par_byte_in),
    .par_valid_out(par_valid_in));
  ccd_top uut (.mclk_in, .rst_b_in, .cdb_byte_in, .cdb_valid_in, .cdb_start_in,
    .par_byte_in, .par_valid_in, .own_type_in, .other_pending_in, .src_byte_in, .dst_byte_in,
    .xfer_valid_in, .xfer_done_in, .busy_out(), .want_data_out, .par_len_out, .compare_out,
    .lun_out, .pad_out, .cat_out, .func_out, .seg_fmt_out(), .desc_byte_out(), .desc_valid_out(),
    .desc_pos_out(), .desc_idx_out(), .sched_prio_out, .copy_run_out, .other_hold_out, .dst_byte_out,
    .dst_wr_out, .done_out, .check_out, .sense_key_out, .asc_out, .seg_num_out);
  // ==========================================================
  // clock, value compare and verdict
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // written bytes must match the queue; compare mode writes nothing
  always @(posedge mclk_in) if (dst_wr_out === 1'b1) cmp8(dst_byte_out, exp_q.size() ? exp_q.pop_front() : 'x, "dst");
  // one command end to end: extra adds to or trims the list length
  task automatic run(input bit cmp, input logic [4:0] fn, input logic [2:0] pr, input int ns, input int ex, input bit mis);
    logic [7:0] l[$];
    logic [7:0] b;
    int         len;
    int         seg;
    bit         bad;
    seg = (fn < 2) ? 12 : 16;
    len = 4 + ns * seg + ex;
    bad = len > 0 && (ns == 0 || ex != 0 || fn > 4 || ns > 256);
    // own unit is block type 0 or sequential type 1, by priority bit 1
    bad = bad || (len > 0 && fn > 1 && (fn == 2) == pr[1]);
    for (int i = 0; i < len; i++) l.push_back(i == 0 ? {fn, pr} : 8'($urandom));
    other_pending_in <= 1'($urandom);
    own_type_in <= {4'h0, pr[1]};
    host.send_cmd(cmp, len[23:0]);
    if (len > 0) host.send_list(l);
    for (int i = 0; i < 300 && done_out !== 1'b1 && copy_run_out !== 1'b1; i++) @(posedge mclk_in);
    // a lax copy sits still while another command waits; that command then ends
    cmp8({7'h0, copy_run_out}, {7'h0, len > 0 && !bad && !(other_pending_in && pr > 3'h1)}, "run");
    if (len > 0 && !bad && copy_run_out !== 1'b1) begin
      other_pending_in <= 1'b0;
      for (int i = 0; i < 5 && copy_run_out !== 1'b1; i++) @(posedge mclk_in);
    end
    if (copy_run_out === 1'b1) begin
      cmp8({4'h0, other_hold_out, sched_prio_out}, {4'h0, pr == 3'h0, pr}, "prio");
      cmp8({3'h0, func_out}, {3'h0, fn}, "func");
      cmp8({7'h0, cat_out}, {7'h0, l[len - seg][3]}, "cat");
      for (int i = 0; i < 8; i++) begin
        b = 8'($urandom);
        {src_byte_in, dst_byte_in, xfer_valid_in} <= {b, (mis && i == 5) ? ~b : b, 1'b1};
        if (!cmp) exp_q.push_back(b);
        @(posedge mclk_in);
      end
      {xfer_valid_in, xfer_done_in} <= 2'b01;
      @(posedge mclk_in);
      xfer_done_in <= 1'b0;
      for (int i = 0; i < 10 && done_out !== 1'b1; i++) @(posedge mclk_in);
    end
    cmp8({7'h0, done_out}, 8'h01, "done");
    @(posedge mclk_in);
    cmp8({check_out, 3'h0, sense_key_out}, bad ? 8'h85 : (cmp && mis) ? 8'h8e : 8'h00, "status");
    if (bad) cmp8(asc_out, 8'h26, "asc");
    cmp8({compare_out, lun_out, pad_out, 3'h0}, {cmp, 3'h2, 1'b1, 3'h0}, "block");
    cmp8(par_len_out[7:0], len[7:0], "len lo");
    cmp8(par_len_out[15:8], len[15:8], "len mid");
    cmp8(seg_num_out[7:0], 8'((len > 4) ? (len - 4) / seg : 0), "segments");
    $display("test end: compare %0d code %0d length %0d", cmp, fn, len);
  endtask : run
  // ==========================================================
  // reset, then the scenario list
  initial begin
    {rst_b_in, other_pending_in, xfer_valid_in, xfer_done_in} = 4'h0;
    {src_byte_in, dst_byte_in, own_type_in} = 21'h0;
    void'($urandom(50320));
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    for (int f = 0; f < 6; f++) run(0, f[4:0], f[2:0], 1, 0, 0);
    run(0, 2, 0, 0, -4, 0);
    run(0, 2, 3, 0, -1, 0);
    run(0, 0, 2, 2, 5, 0);
    run(1, 2, 1, 2, 0, 0);
    run(1, 0, 0, 1, 0, 1);
    run(0, 3, 7, 257, 0, 0);
    summarize();
  end
  // watchdog, about four times the expected run
  initial begin
    #2_000_000;
    error_cnt++;
    summarize();
  end
endmodule : test_copy_compare_command_decoder
